// *** pcitc_defines.svh ***
// Constants for the PCI transaction-control block.
// Assumes inclusion by the package, the top module and the bench.
// Summary of operation
// - As initiator, a stop sampled low ends the current transaction in the next bus cycle.
// - As target, stop is asserted to disconnect any access after one dword, on initiator wait states, or to retry while locked.
// - Stop and device-select drivers are released whenever the block is neither initiator nor target.
// - Select high with a config read or write command in the address phase claims the access next cycle.
// - As initiator, no claim within six bus cycles after the address aborts and raises an interrupt.
// - As target, device select is driven low once the presented address is recognised as ours.
// - Lock and frame both low while we are the addressed target make that initiator our owner.
// - Ownership holds until frame and lock are seen high together.
// - As initiator the block never asserts lock.
// - Lock, select, stop and device select are sampled, and our copies updated, on the rising bus clock.
`ifndef PCITC_DEFINES_SVH
`define PCITC_DEFINES_SVH
`define PCITC_CMD_CFG_RD   4'hA
`define PCITC_CMD_CFG_WR   4'hB
`define PCITC_DEVSEL_TMO   6
`define PCITC_SYNC_STAGES  2
`endif

// *** pcitc_pkg.sv ***
// Types shared by the PCI transaction-control block.
// Assumes nothing of its surroundings.
`include "pcitc_defines.svh"
package pcitc_pkg;
  typedef enum logic [3:0] {
    PCITC_M_IDLE = 4'b0001,
    PCITC_M_ADDR = 4'b0010,
    PCITC_M_WAIT = 4'b0100,
    PCITC_M_TURN = 4'b1000
  } pcitc_mst_e;
  typedef enum logic [3:0] {
    PCITC_T_IDLE = 4'b0001,
    PCITC_T_DATA = 4'b0010,
    PCITC_T_STOP = 4'b0100,
    PCITC_T_TURN = 4'b1000
  } pcitc_tgt_e;
endpackage

// *** pcitc_sync.sv ***
// Two-flop synchroniser for levels and toggles.
// Assumes each bit changes at most once per destination sample window.
module pcitc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_i) begin
    meta_ff <= async_i;
    sync_ff <= meta_ff;
  end

  assign sync_o = sync_ff;
endmodule

// *** pcitc_top.sv ***
// PCI transaction control: initiator timeout, target claim, stop, lock.
// Assumes bus pins are synchronous to pci_bus_clk_i; the system side
// runs on clk_sys_i and talks to it through toggle handshakes.
`include "pcitc_defines.svh"
module pcitc_top import pcitc_pkg::*; #(
  parameter int TMO_CYC = `PCITC_DEVSEL_TMO
) (
  // System side
  input  wire logic       clk_sys_i,
  input  wire logic       reset_n_i,
  input  wire logic       mst_start_i,
  input  wire logic [3:0] mst_cmd_i,
  output logic            mst_ready_o,
  output logic            mst_done_o,
  output logic            mst_abort_o,
  input  wire logic       int_clr_i,
  output logic            irq_o,
  // Bus inputs
  input  wire logic       pci_bus_clk_i,
  input  wire logic       frame_n_i,
  input  wire logic       irdy_n_i,
  input  wire logic       trdy_n_i,
  input  wire logic       stop_n_i,
  input  wire logic       devsel_n_i,
  input  wire logic       lock_n_i,
  input  wire logic       idsel_i,
  input  wire logic [3:0] cbe_i,
  input  wire logic       addr_hit_i,
  // Bus outputs
  output logic            frame_n_o,
  output logic            frame_oe_o,
  output logic            irdy_n_o,
  output logic            irdy_oe_o,
  output logic [3:0]      cbe_o,
  output logic            cbe_oe_o,
  output logic            trdy_n_o,
  output logic            trdy_oe_o,
  output logic            stop_n_o,
  output logic            stop_oe_o,
  output logic            devsel_n_o,
  output logic            devsel_oe_o,
  output logic            lock_n_o,
  output logic            lock_oe_o,
  output logic            int_n_o,
  output logic            int_oe_o,
  output logic            cfg_access_o
);
  localparam int TW = $clog2(TMO_CYC + 1);

  // System domain
  logic       s_req_tgl_ff, s_busy_ff, s_done_seen_ff, s_done_ff, s_abort_ff, s_clr_tgl_ff;
  logic [3:0] s_cmd_ff;
  logic [1:0] s_sync;
  logic       s_done_edge;
  // Link domain
  logic [2:0] l_sync;
  logic       l_rst_n, l_req_seen_ff, l_clr_seen_ff, l_pend_ff, l_done_tgl_ff, l_abort_ff;
  logic       l_int_ff, l_frame_q_ff, l_lock_ff, l_cfg_ff;
  logic       l_trdy_n_ff, l_stop_n_ff, l_devsel_n_ff, l_t_oe_ff;
  logic       l_frame_n_ff, l_irdy_n_ff, l_m_oe_ff, l_cfg_acc_ff;
  logic [3:0] l_cbe_ff;
  logic [TW-1:0] l_mcnt_ff;
  pcitc_mst_e l_mst_st;
  pcitc_tgt_e l_tgt_st;
  logic       l_addr_ph, l_claim, l_retry, l_xfer, l_clr_edge;

  pcitc_sync #(.WIDTH(3)) u_sync_link (
    .clk_i   (pci_bus_clk_i),
    .async_i ({reset_n_i, s_req_tgl_ff, s_clr_tgl_ff}),
    .sync_o  (l_sync)
  );
  pcitc_sync #(.WIDTH(2)) u_sync_sys (
    .clk_i   (clk_sys_i),
    .async_i ({l_done_tgl_ff, l_int_ff}),
    .sync_o  (s_sync)
  );

  assign l_rst_n     = l_sync[2];
  assign s_done_edge = s_sync[1] ^ s_done_seen_ff;
  assign mst_ready_o = !s_busy_ff;
  assign mst_done_o  = s_done_ff;
  assign mst_abort_o = s_abort_ff;
  assign irq_o       = s_sync[0];

  // Request handshake; command stays stable while busy
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_req_tgl_ff <= 1'b0;
      s_busy_ff    <= 1'b0;
      s_cmd_ff     <= 4'h0;
    end else if (mst_start_i && !s_busy_ff) begin
      s_req_tgl_ff <= !s_req_tgl_ff;
      s_busy_ff    <= 1'b1;
      s_cmd_ff     <= mst_cmd_i;
    end else if (s_done_edge) begin
      s_busy_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      s_done_seen_ff <= 1'b0;
      s_done_ff      <= 1'b0;
      s_abort_ff     <= 1'b0;
      s_clr_tgl_ff   <= 1'b0;
    end else begin
      s_done_seen_ff <= s_sync[1];
      s_done_ff      <= s_done_edge;
      if (s_done_edge) begin
        s_abort_ff <= l_abort_ff;
      end
      if (int_clr_i) begin
        s_clr_tgl_ff <= !s_clr_tgl_ff;
      end
    end
  end

  // Bus phase decode, all on the rising bus clock
  assign l_addr_ph  = l_frame_q_ff && !frame_n_i && (l_mst_st == PCITC_M_IDLE);
  assign l_claim    = (idsel_i && (cbe_i == `PCITC_CMD_CFG_RD || cbe_i == `PCITC_CMD_CFG_WR))
                      || addr_hit_i;
  assign l_retry    = l_lock_ff && !lock_n_i;
  assign l_xfer     = (l_tgt_st == PCITC_T_DATA) && !irdy_n_i && !l_trdy_n_ff;
  assign l_clr_edge = l_sync[0] ^ l_clr_seen_ff;

  always_ff @(posedge pci_bus_clk_i) begin
    if (!l_rst_n) begin
      l_frame_q_ff  <= 1'b1;
      l_req_seen_ff <= 1'b0;
      l_clr_seen_ff <= 1'b0;
      l_pend_ff     <= 1'b0;
    end else begin
      l_frame_q_ff  <= frame_n_i;
      l_req_seen_ff <= l_sync[1];
      l_clr_seen_ff <= l_sync[0];
      if (l_sync[1] ^ l_req_seen_ff) begin
        l_pend_ff <= 1'b1;
      end else if (l_mst_st == PCITC_M_ADDR) begin
        l_pend_ff <= 1'b0;
      end
    end
  end

  // Initiator machine
  always_ff @(posedge pci_bus_clk_i) begin
    if (!l_rst_n) begin
      l_mst_st      <= PCITC_M_IDLE;
      l_mcnt_ff     <= '0;
      l_frame_n_ff  <= 1'b1;
      l_irdy_n_ff   <= 1'b1;
      l_m_oe_ff     <= 1'b0;
      l_cbe_ff      <= 4'h0;
      l_done_tgl_ff <= 1'b0;
      l_abort_ff    <= 1'b0;
    end else begin
      unique case (l_mst_st)
        PCITC_M_IDLE: begin
          l_m_oe_ff <= 1'b0;
          if (l_pend_ff && frame_n_i && irdy_n_i && l_tgt_st == PCITC_T_IDLE) begin
            l_mst_st     <= PCITC_M_ADDR;
            l_m_oe_ff    <= 1'b1;
            l_frame_n_ff <= 1'b0;
            l_cbe_ff     <= s_cmd_ff;
          end
        end
        PCITC_M_ADDR: begin
          l_mst_st     <= PCITC_M_WAIT;
          l_mcnt_ff    <= TW'(1);
          l_frame_n_ff <= 1'b1;
          l_irdy_n_ff  <= 1'b0;
        end
        PCITC_M_WAIT: begin
          if (!stop_n_i || (!devsel_n_i && !trdy_n_i)) begin
            l_mst_st      <= PCITC_M_TURN;
            l_irdy_n_ff   <= 1'b1;
            l_abort_ff    <= 1'b0;
            l_done_tgl_ff <= !l_done_tgl_ff;
          end else if (devsel_n_i && l_mcnt_ff == TW'(TMO_CYC)) begin
            l_mst_st      <= PCITC_M_TURN;
            l_irdy_n_ff   <= 1'b1;
            l_abort_ff    <= 1'b1;
            l_done_tgl_ff <= !l_done_tgl_ff;
          end else if (devsel_n_i) begin
            l_mcnt_ff <= l_mcnt_ff + TW'(1);
          end
        end
        PCITC_M_TURN: begin
          l_mst_st  <= PCITC_M_IDLE;
          l_m_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Abort interrupt; a new abort wins over a clear
  always_ff @(posedge pci_bus_clk_i) begin
    if (!l_rst_n) begin
      l_int_ff <= 1'b0;
    end else if (l_mst_st == PCITC_M_WAIT && devsel_n_i && stop_n_i
                 && l_mcnt_ff == TW'(TMO_CYC)) begin
      l_int_ff <= 1'b1;
    end else if (l_clr_edge) begin
      l_int_ff <= 1'b0;
    end
  end

  // Target machine
  always_ff @(posedge pci_bus_clk_i) begin
    if (!l_rst_n) begin
      l_tgt_st      <= PCITC_T_IDLE;
      l_trdy_n_ff   <= 1'b1;
      l_stop_n_ff   <= 1'b1;
      l_devsel_n_ff <= 1'b1;
      l_t_oe_ff     <= 1'b0;
      l_cfg_ff      <= 1'b0;
    end else begin
      unique case (l_tgt_st)
        PCITC_T_IDLE: begin
          l_t_oe_ff <= 1'b0;
          if (l_addr_ph && l_claim) begin
            l_t_oe_ff     <= 1'b1;
            l_devsel_n_ff <= 1'b0;
            l_cfg_ff      <= idsel_i && !addr_hit_i;
            if (l_retry) begin
              l_tgt_st    <= PCITC_T_STOP;
              l_stop_n_ff <= 1'b0;
            end else begin
              l_tgt_st    <= PCITC_T_DATA;
              l_trdy_n_ff <= 1'b0;
              l_stop_n_ff <= !(idsel_i && !addr_hit_i);
            end
          end
        end
        PCITC_T_DATA: begin
          if (l_xfer && frame_n_i) begin
            l_tgt_st      <= PCITC_T_TURN;
            l_trdy_n_ff   <= 1'b1;
            l_stop_n_ff   <= 1'b1;
            l_devsel_n_ff <= 1'b1;
          end else if (l_xfer) begin
            l_tgt_st    <= PCITC_T_STOP;
            l_trdy_n_ff <= 1'b1;
            l_stop_n_ff <= 1'b0;
          end else if (irdy_n_i) begin
            l_stop_n_ff <= 1'b0;
          end
        end
        PCITC_T_STOP: begin
          if (frame_n_i) begin
            l_tgt_st      <= PCITC_T_TURN;
            l_stop_n_ff   <= 1'b1;
            l_devsel_n_ff <= 1'b1;
          end
        end
        PCITC_T_TURN: begin
          l_tgt_st  <= PCITC_T_IDLE;
          l_t_oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // Lock ownership and config access pulse
  always_ff @(posedge pci_bus_clk_i) begin
    if (!l_rst_n) begin
      l_lock_ff    <= 1'b0;
      l_cfg_acc_ff <= 1'b0;
    end else begin
      l_cfg_acc_ff <= l_xfer && l_cfg_ff;
      if (l_tgt_st == PCITC_T_DATA && !lock_n_i && !frame_n_i) begin
        l_lock_ff <= 1'b1;
      end else if (frame_n_i && lock_n_i) begin
        l_lock_ff <= 1'b0;
      end
    end
  end

  assign frame_n_o    = l_frame_n_ff;
  assign frame_oe_o   = l_m_oe_ff;
  assign irdy_n_o     = l_irdy_n_ff;
  assign irdy_oe_o    = l_m_oe_ff;
  assign cbe_o        = l_cbe_ff;
  assign cbe_oe_o     = l_m_oe_ff && (l_mst_st == PCITC_M_ADDR);
  assign trdy_n_o     = l_trdy_n_ff;
  assign trdy_oe_o    = l_t_oe_ff;
  assign stop_n_o     = l_stop_n_ff;
  assign stop_oe_o    = l_t_oe_ff;
  assign devsel_n_o   = l_devsel_n_ff;
  assign devsel_oe_o  = l_t_oe_ff;
  assign lock_n_o     = 1'b1;
  assign lock_oe_o    = 1'b0;
  assign int_n_o      = 1'b0;
  assign int_oe_o     = l_int_ff;
  assign cfg_access_o = l_cfg_acc_ff;

  // Checks on the bus clock
  sequence s_cfg_addr;
    l_addr_ph && idsel_i && !addr_hit_i && !l_retry
    && (cbe_i == `PCITC_CMD_CFG_RD || cbe_i == `PCITC_CMD_CFG_WR);
  endsequence
  sequence s_no_claim;
    (l_mst_st == PCITC_M_WAIT && devsel_n_i && stop_n_i)[*6];
  endsequence

  chk_stop_ends_mst: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_mst_st == PCITC_M_WAIT && !stop_n_i |=> l_mst_st == PCITC_M_TURN && irdy_n_o ##1 !irdy_oe_o)
    else $error("initiator did not end after stop");
  chk_stop_cause: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    $fell(l_stop_n_ff) && $past(l_tgt_st == PCITC_T_DATA)
    |-> $past(l_cfg_ff) || $past(irdy_n_i) || $past(!frame_n_i))
    else $error("target stop without cause");
  chk_idle_release: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    $past(l_tgt_st == PCITC_T_IDLE) && l_tgt_st == PCITC_T_IDLE |-> !stop_oe_o && !devsel_oe_o)
    else $error("stop or devsel driven while idle");
  chk_cfg_claim: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    s_cfg_addr |=> !devsel_n_o && devsel_oe_o && !trdy_n_o && !stop_n_o)
    else $error("config access not claimed next cycle");
  chk_devsel_tmo: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_mst_st == PCITC_M_ADDR ##1 s_no_claim |=> l_int_ff && l_abort_ff && irdy_n_o)
    else $error("missing abort after six cycles");
  chk_abort_late: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    $rose(l_abort_ff) |-> $past(l_mcnt_ff) == TW'(TMO_CYC) && $past(devsel_n_i))
    else $error("abort before timeout");
  chk_mem_claim: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_addr_ph && addr_hit_i |=> !devsel_n_o && devsel_oe_o)
    else $error("recognised address not claimed");
  chk_lock_reject: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_addr_ph && l_claim && l_retry |=> !stop_n_o && trdy_n_o && !devsel_n_o ##1 trdy_n_o)
    else $error("locked target did not retry");
  chk_lock_hold: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_lock_ff && !(frame_n_i && lock_n_i) |=> l_lock_ff)
    else $error("lock dropped before release");
  chk_lock_take: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_tgt_st == PCITC_T_DATA && !lock_n_i && !frame_n_i |=> l_lock_ff)
    else $error("ownership not taken");
  chk_no_lock: assert property (@(posedge pci_bus_clk_i) disable iff (!l_rst_n)
    l_mst_st != PCITC_M_IDLE |-> !lock_oe_o)
    else $error("initiator drove lock");
endmodule

// *** pcitc_bus_model.sv ***
// Far-side target model that claims the block's initiator cycles.
// Assumes the bench resolves shared lines with pull-ups (released = high).
module pcitc_bus_model (
  // Bus seen from the block
  input  wire logic       pci_bus_clk_i,
  input  wire logic       frame_oe_i,
  input  wire logic       frame_n_i,
  input  wire logic       irdy_oe_i,
  // Delay in cycles; mode 0 ready, 1 stop, 2 silent
  input  wire logic [2:0] dly_i,
  input  wire logic [1:0] mode_i,
  // Drive, high when released
  output logic            devsel_n_o,
  output logic            trdy_n_o,
  output logic            stop_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       act_ff = 1'b0;
  logic [3:0] cnt_ff = 4'h0;
  initial begin
    devsel_n_o = 1'b1;
    trdy_n_o   = 1'b1;
    stop_n_o   = 1'b1;
  end
  always @(posedge pci_bus_clk_i) begin
    if (!act_ff) begin
      act_ff <= frame_oe_i && !frame_n_i;
      cnt_ff <= 4'h0;
    end else if (!irdy_oe_i && cnt_ff > 4'h1) begin
      act_ff     <= 1'b0;
      devsel_n_o <= 1'b1;
      trdy_n_o   <= 1'b1;
      stop_n_o   <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
      if (cnt_ff == {1'b0, dly_i} && mode_i != 2'h2) begin
        devsel_n_o <= 1'b0;
        trdy_n_o   <= mode_i[0];
        stop_n_o   <= !mode_i[0];
      end
    end
  end
endmodule

// *** pci_transaction_control_test.sv ***
// Bench for the PCI transaction-control block: initiator, target, lock.
// Assumes pull-ups on shared bus lines and the far-side target model.
`include "pcitc_defines.svh"
module pci_transaction_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys_i = 0, reset_n_i = 0, mst_start_i = 0, int_clr_i = 0;
  logic       pci_bus_clk_i = 0, idsel_i = 0, addr_hit_i = 0;
  logic [3:0] mst_cmd_i = 4'h6, cbe_i = 4'h0;
  logic       tb_frame = 1, tb_irdy = 1, tb_lock = 1, s1 = 0, s2 = 0;
  logic       frame_n_i, irdy_n_i, trdy_n_i, stop_n_i, devsel_n_i, lock_n_i;
  logic       mst_ready_o, mst_done_o, mst_abort_o, irq_o, frame_n_o, frame_oe_o;
  logic       irdy_n_o, irdy_oe_o, trdy_n_o, trdy_oe_o, stop_n_o, stop_oe_o;
  logic       devsel_n_o, devsel_oe_o, lock_n_o, lock_oe_o, int_oe_o, cfg_access_o;
  logic       m_devsel, m_trdy, m_stop, cbe_oe_o, int_n_o;
  logic [3:0] cbe_o, exp_cmd = 4'h0;
  logic [2:0] dly = 3'h0;
  logic [1:0] mode = 2'h0;
  logic       exp_q[$];
  int         n_errors = 0, tests_run = 0, n_cfg = 0, n_cfg_seen = 0, cyc = 0, owned = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  always #7.5 pci_bus_clk_i = ~pci_bus_clk_i;
  // Wired bus: pull-ups, released lines read high
  assign frame_n_i  = frame_oe_o ? frame_n_o : tb_frame;
  assign irdy_n_i   = irdy_oe_o ? irdy_n_o : tb_irdy;
  assign trdy_n_i   = (trdy_oe_o ? trdy_n_o : 1'b1) & m_trdy;
  assign stop_n_i   = (stop_oe_o ? stop_n_o : 1'b1) & m_stop;
  assign devsel_n_i = (devsel_oe_o ? devsel_n_o : 1'b1) & m_devsel;
  assign lock_n_i   = (lock_oe_o ? lock_n_o : 1'b1) & tb_lock;
  pcitc_top dut (
    .clk_sys_i, .reset_n_i, .mst_start_i, .mst_cmd_i, .mst_ready_o, .mst_done_o, .mst_abort_o,
    .int_clr_i, .irq_o, .pci_bus_clk_i, .frame_n_i, .irdy_n_i, .trdy_n_i, .stop_n_i,
    .devsel_n_i, .lock_n_i, .idsel_i, .cbe_i, .addr_hit_i, .frame_n_o, .frame_oe_o, .irdy_n_o,
    .irdy_oe_o, .cbe_o, .cbe_oe_o, .trdy_n_o, .trdy_oe_o, .stop_n_o, .stop_oe_o,
    .devsel_n_o, .devsel_oe_o, .lock_n_o, .lock_oe_o, .int_n_o, .int_oe_o, .cfg_access_o
  );
  pcitc_bus_model far (
    .pci_bus_clk_i, .frame_oe_i(frame_oe_o), .frame_n_i(frame_n_o), .irdy_oe_i(irdy_oe_o),
    .dly_i(dly), .mode_i(mode), .devsel_n_o(m_devsel), .trdy_n_o(m_trdy), .stop_n_o(m_stop)
  );
  task automatic check(input logic seen, input logic exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Initiator transfer against the far-side model
  task automatic ini(input logic [2:0] d, input logic [1:0] m);
    logic ab;
    int   k;
    dly  = d;
    mode = m;
    exp_q.push_back(m == 2'h2);
    @(negedge clk_sys_i);
    for (k = 0; k < 100 && mst_ready_o !== 1'b1; k++) @(negedge clk_sys_i);
    mst_start_i = 1'b1;
    mst_cmd_i   = {3'b011, 1'($urandom)};
    exp_cmd     = mst_cmd_i;
    @(negedge clk_sys_i);
    mst_start_i = 1'b0;
    for (k = 0; k < 400 && mst_done_o !== 1'b1; k++) @(negedge clk_sys_i);
    ab = exp_q.pop_front();
    check(k < 400, 1'b1, "done");
    check(mst_abort_o, ab, "abort");
    check(lock_oe_o, 1'b0, "lock_oe");
    repeat (20) @(negedge clk_sys_i);
    check(irq_o, ab, "irq");
    check(int_oe_o, ab, "int_oe");
    check(int_n_o, 1'b0, "int_n");
    int_clr_i = 1'b1;
    @(negedge clk_sys_i);
    int_clr_i = 1'b0;
    repeat (20) @(negedge clk_sys_i);
    check(irq_o, 1'b0, "irq_clr");
  endtask
  // Target transfer driven by another initiator
  task automatic tgt(input logic sel, input logic [3:0] cmd, input logic hit,
                     input logic lk_a, input logic fr_d, input logic lk_end);
    logic claim, retry, cfg;
    claim = hit || (sel && (cmd == `PCITC_CMD_CFG_RD || cmd == `PCITC_CMD_CFG_WR));
    retry = claim && owned != 0 && !lk_a;
    cfg   = claim && !hit && !retry;
    @(negedge pci_bus_clk_i);
    tb_frame   = 1'b0;
    idsel_i    = sel;
    cbe_i      = cmd;
    addr_hit_i = hit;
    tb_lock    = lk_a;
    @(negedge pci_bus_clk_i);
    check(devsel_oe_o, claim, "devsel_oe");
    check(stop_oe_o, claim, "stop_oe");
    if (claim) begin
      check(devsel_n_o, 1'b0, "devsel");
      check(stop_n_o, !(cfg || retry), "stop");
      check(trdy_n_o, retry, "trdy");
    end
    tb_frame   = fr_d;
    tb_irdy    = 1'b0;
    idsel_i    = 1'b0;
    addr_hit_i = 1'b0;
    @(negedge pci_bus_clk_i);
    tb_frame = 1'b1;
    tb_irdy  = 1'b1;
    tb_lock  = lk_end;
    repeat (3) @(negedge pci_bus_clk_i);
    check(devsel_oe_o | stop_oe_o | trdy_oe_o, 1'b0, "released");
    if (claim && !lk_a && !fr_d) owned = 1;
    if (lk_end) owned = 0;
    n_cfg += int'(cfg);
  endtask
  // Initiator must end the cycle after stop is sampled low
  always @(posedge pci_bus_clk_i) begin
    s1 <= irdy_oe_o && !irdy_n_o && !stop_n_i;
    s2 <= s1;
    if (cfg_access_o === 1'b1) n_cfg_seen++;
  end
  always @(negedge pci_bus_clk_i) if (s2) check(irdy_n_o, 1'b1, "irdy_end");
  // Address phase of our own initiator cycle carries the requested command
  always @(negedge pci_bus_clk_i) begin
    if (cbe_oe_o === 1'b1) begin
      check(cbe_o == exp_cmd, 1'b1, "cbe");
      check(frame_n_o, 1'b0, "frame");
      check(frame_oe_o, 1'b1, "frame_oe");
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    logic [3:0] cmds[3];
    cmds = '{`PCITC_CMD_CFG_RD, `PCITC_CMD_CFG_WR, 4'h6};
    void'($urandom(32'h430e));
    repeat (8) @(posedge pci_bus_clk_i);
    @(negedge clk_sys_i);
    reset_n_i = 1'b1;
    repeat (4) @(posedge pci_bus_clk_i);
    for (int i = 0; i < 4; i++) ini(3'($urandom % 4), 2'(i % 2));
    ini(3'h0, 2'h2);
    for (int i = 0; i < 3; i++) tgt(1'b1, cmds[i], 1'b0, 1'b1, 1'b1, 1'b1);
    tgt(1'b0, `PCITC_CMD_CFG_RD, 1'b0, 1'b1, 1'b1, 1'b1);
    tgt(1'b0, 4'h7, 1'b1, 1'b1, 1'b1, 1'b1);
    tgt(1'b0, 4'h6, 1'b1, 1'b0, 1'b0, 1'b0);
    tgt(1'b0, 4'h6, 1'b1, 1'b0, 1'b1, 1'b0);
    tgt(1'b0, 4'h7, 1'b1, 1'b1, 1'b1, 1'b1);
    tgt(1'b0, 4'h6, 1'b1, 1'b0, 1'b1, 1'b1);
    ini(3'h2, 2'h1);
    check(n_cfg_seen == n_cfg, 1'b1, "cfg_count");
    final_report();
  end
endmodule
